// ### core/ddm_addr_fmt.sv
`timescale 1ns/100ps
`default_nettype none
module ddm_addr_fmt
  import ddm_pkg::*;
(
  input  wire logic        wide16,   // 16-bit transfer mode
  input  wire logic [15:0] curAddr,  // Current address
  input  wire logic [7:0]  page,     // Page byte
  output var  logic [23:0] adValue   // Address-phase value
);

  always_comb
  begin
    if (wide16)
      adValue = {page[7:1], curAddr, 1'h0};
    else
      adValue = {page, curAddr};
  end

endmodule // ddm_addr_fmt
`default_nettype wire

// ### core/ddm_channel.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Decode 16-byte I/O block at base pointer
// - Obsolete legacy bits are read-only, inert
// - Reserved locations read zero, ignore writes
// - 8-bit: address on 15-0, page on 23-16
// - 16-bit: address shifted up one, page 7-1
// - Offset 00h writes start, reads current address
// - Page byte at 02h, read/write, resets zero
// - Offset 04h writes count, reads remaining count
// - Count drops one or two per transfer
// - Command bit 2 set disables the channel
// - Status 7-4 mirror card request line
// - Request status ignores the mask bit
// - Status 3-0 all set at terminal count
// - Terminal flags clear on read or reset
// - Offset 08h reads status, writes command
// - Any write at 09h arms software request
// - Mode selects transfer mode and type
// - Direction bit and auto-reload bit
// - Mask blocks card requests, set on removal
// - Master clear returns all registers to default
module ddm_channel
  import ddm_pkg::*;
(
  input  wire logic                  clk,               // 10 MHz clock
  input  wire logic                  arst_n,            // Async reset, active low
  input  wire ddm_io_req_t           ioReq,             // Byte-wide I/O access
  input  wire logic [WIN_BASE_W-1:0] windowBasePointer, // Window base, address bits 15-4
  input  wire logic                  cardRequestPin,    // Card DMA request pin
  input  wire logic                  cardPresentPin,    // Card present pin
  input  wire logic                  wide16,            // 16-bit transfer mode
  input  wire logic                  transferDone,      // One transfer completed
  output var  logic [7:0]            ioRdata,           // Read data
  output var  logic                  ioRdValid,         // Read data valid pulse
  output var  logic [23:0]           adAddress,         // Address-phase value
  output var  logic                  channelRequest,    // Service request to master
  output var  logic                  terminalCount,     // Terminal count pulse
  output var  logic [1:0]            transferModeSel,   // Demand/single/block
  output var  logic [1:0]            transferDirType    // None/write/read memory
);

  logic                 cardRequest;
  logic                 cardPresent;
  logic                 inWin;
  logic [WIN_OFS_W-1:0] ofs;
  logic                 wrEn;
  logic                 rdEn;
  logic                 masterClear;
  logic                 xferOk;
  logic                 tcHit;
  logic [15:0]          stepVal;
  logic [23:0]          adValue;
  logic [7:0]           readMux;

  logic [15:0]          baseAddr_reg;
  logic [15:0]          curAddr_reg;
  logic [7:0]           page_reg;
  logic [15:0]          baseCount_reg;
  logic [15:0]          curCount_reg;
  logic                 ctlDisable_reg;
  ddm_mode_t            mode_reg;
  logic                 mask_reg;
  logic                 swReq_reg;
  logic                 tcFlag_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  ddm_sync u_reqSync
  (
    .clk      (clk),
    .arst_n   (arst_n),
    .pinIn    (cardRequestPin),
    .levelOut (cardRequest)
  );

  ddm_sync u_presSync
  (
    .clk      (clk),
    .arst_n   (arst_n),
    .pinIn    (cardPresentPin),
    .levelOut (cardPresent)
  );

  ddm_addr_fmt u_fmt
  (
    .wide16  (wide16),
    .curAddr (curAddr_reg),
    .page    (page_reg),
    .adValue (adValue)
  );

  assign inWin       = (ioReq.addr[15:WIN_OFS_W] == windowBasePointer);
  assign ofs         = ioReq.addr[WIN_OFS_W-1:0];
  assign wrEn        = ioReq.wr && inWin;
  assign rdEn        = ioReq.rd && inWin;
  assign masterClear = wrEn && (ofs == OFS_MCLEAR);
  assign stepVal     = wide16 ? STEP_WORD : STEP_BYTE;
  assign xferOk      = transferDone && !ctlDisable_reg;
  // Count below one step means this transfer runs past zero
  assign tcHit       = xferOk && (curCount_reg < stepVal);

  // Address: host write beats a transfer in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      baseAddr_reg <= ADDR_RST;
      curAddr_reg  <= ADDR_RST;
    end
    else if (masterClear)
    begin
      baseAddr_reg <= ADDR_RST;
      curAddr_reg  <= ADDR_RST;
    end
    else if (wrEn && (ofs == OFS_ADDR_LO))
    begin
      baseAddr_reg[7:0] <= ioReq.wdata;
      curAddr_reg[7:0]  <= ioReq.wdata;
    end
    else if (wrEn && (ofs == OFS_ADDR_HI))
    begin
      baseAddr_reg[15:8] <= ioReq.wdata;
      curAddr_reg[15:8]  <= ioReq.wdata;
    end
    else if (tcHit && mode_reg.autoReload)
      curAddr_reg <= baseAddr_reg;
    else if (xferOk && mode_reg.dir)
      curAddr_reg <= curAddr_reg - ADDR_STEP;
    else if (xferOk)
      curAddr_reg <= curAddr_reg + ADDR_STEP;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      page_reg <= PAGE_RST;
    else if (masterClear)
      page_reg <= PAGE_RST;
    else if (wrEn && (ofs == OFS_PAGE))
      page_reg <= ioReq.wdata;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      baseCount_reg <= COUNT_RST;
      curCount_reg  <= COUNT_RST;
    end
    else if (masterClear)
    begin
      baseCount_reg <= COUNT_RST;
      curCount_reg  <= COUNT_RST;
    end
    else if (wrEn && (ofs == OFS_COUNT_LO))
    begin
      baseCount_reg[7:0] <= ioReq.wdata;
      curCount_reg[7:0]  <= ioReq.wdata;
    end
    else if (wrEn && (ofs == OFS_COUNT_HI))
    begin
      baseCount_reg[15:8] <= ioReq.wdata;
      curCount_reg[15:8]  <= ioReq.wdata;
    end
    else if (tcHit && mode_reg.autoReload)
      curCount_reg <= baseCount_reg;
    else if (xferOk)
      curCount_reg <= curCount_reg - stepVal;
  end

  // Only bit 2 of the command byte is stored; the rest are inert
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ctlDisable_reg <= DISABLE_RST;
    else if (masterClear)
      ctlDisable_reg <= DISABLE_RST;
    else if (wrEn && (ofs == OFS_CMD_STAT))
      ctlDisable_reg <= ioReq.wdata[CMD_DISABLE_BIT];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mode_reg <= MODE_RST;
    else if (masterClear)
      mode_reg <= MODE_RST;
    else if (wrEn && (ofs == OFS_MODE))
    begin
      mode_reg.sel        <= ioReq.wdata[MODE_SEL_HI:MODE_SEL_LO];
      mode_reg.dir        <= ioReq.wdata[MODE_DIR_BIT];
      mode_reg.autoReload <= ioReq.wdata[MODE_AUTO_BIT];
      mode_reg.transfer_direction_type   <= ioReq.wdata[MODE_TYPE_HI:MODE_TYPE_LO];
    end
  end

  // Removal wins over a host write that would clear the mask
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mask_reg <= MASK_RST;
    else if (masterClear || !cardPresent)
      mask_reg <= MASK_RST;
    else if (wrEn && (ofs == OFS_MASK))
      mask_reg <= ioReq.wdata[MASK_BIT];
  end

  // Armed by any write; retired at terminal count
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      swReq_reg <= 1'h0;
    else if (masterClear)
      swReq_reg <= 1'h0;
    else if (wrEn && (ofs == OFS_SW_REQ))
      swReq_reg <= 1'h1;
    else if (tcHit)
      swReq_reg <= 1'h0;
  end

  // Terminal event beats a status read in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tcFlag_reg <= 1'h0;
    else if (masterClear)
      tcFlag_reg <= 1'h0;
    else if (tcHit)
      tcFlag_reg <= 1'h1;
    else if (rdEn && (ofs == OFS_CMD_STAT))
      tcFlag_reg <= 1'h0;
  end

  always_comb
  begin
    if (ofs == OFS_ADDR_LO)
      readMux = curAddr_reg[7:0];
    else if (ofs == OFS_ADDR_HI)
      readMux = curAddr_reg[15:8];
    else if (ofs == OFS_PAGE)
      readMux = page_reg;
    else if (ofs == OFS_COUNT_LO)
      readMux = curCount_reg[7:0];
    else if (ofs == OFS_COUNT_HI)
      readMux = curCount_reg[15:8];
    else if (ofs == OFS_CMD_STAT)
      readMux = {{4{cardRequest}}, {4{tcFlag_reg}}};
    else if (ofs == OFS_MASK)
      readMux = {7'h00, mask_reg};
    else
      readMux = READ_ZERO;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ioRdata   <= READ_ZERO;
      ioRdValid <= 1'h0;
    end
    else
    begin
      ioRdata   <= rdEn ? readMux : READ_ZERO;
      ioRdValid <= rdEn;
    end
  end

  // Outputs to the master
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      adAddress       <= 24'h000000;
      channelRequest  <= 1'h0;
      terminalCount   <= 1'h0;
      transferModeSel <= SEL_DEMAND;
      transferDirType <= TYPE_NONE;
    end
    else
    begin
      adAddress       <= adValue;
      channelRequest  <= !ctlDisable_reg && ((cardRequest && !mask_reg) || swReq_reg);
      terminalCount   <= tcHit;
      transferModeSel <= mode_reg.sel;
      transferDirType <= mode_reg.transfer_direction_type;
    end
  end

  a_ad_byte_mode: assert property (!wide16 |=> adAddress == {$past(page_reg), $past(curAddr_reg)})
    else $error("8-bit address phase wrong");
  a_ad_word_mode: assert property (wide16 |=> adAddress[0] == 1'h0 && adAddress[16:1] == $past(curAddr_reg)
                                   && adAddress[23:17] == $past(page_reg[7:1]))
    else $error("16-bit address phase wrong");
  a_count_byte_step: assert property (xferOk && !wide16 && !tcHit && !wrEn
                                      |=> curCount_reg == 16'($past(curCount_reg) - 16'h0001))
    else $error("count did not drop by one");
  a_count_word_step: assert property (xferOk && wide16 && !tcHit && !wrEn
                                      |=> curCount_reg == 16'($past(curCount_reg) - 16'h0002))
    else $error("count did not drop by two");
  a_tc_flag_set: assert property (tcHit && !masterClear |=> tcFlag_reg)
    else $error("terminal flags not raised");
  a_status_clear: assert property (rdEn && ofs == OFS_CMD_STAT && !tcHit |=> !tcFlag_reg)
    else $error("terminal flags survive read");
  a_req_status: assert property (rdEn && ofs == OFS_CMD_STAT |=> ioRdata[7:4] == {4{$past(cardRequest)}})
    else $error("request status mismatch");
  a_tc_report: assert property (rdEn && ofs == OFS_CMD_STAT |=> ioRdata[3:0] == {4{$past(tcFlag_reg)}})
    else $error("terminal status mismatch");
  a_mask_blocks: assert property (mask_reg && !swReq_reg |=> !channelRequest)
    else $error("masked request reached master");
  a_removal_masks: assert property (!cardPresent |=> mask_reg)
    else $error("removal did not set mask");
  a_reserved_zero: assert property (rdEn && (ofs == 4'h3 || ofs == 4'hC || ofs == 4'hB)
                                    |=> ioRdata == 8'h00)
    else $error("reserved location not zero");
  a_master_clear: assert property (masterClear |=> mask_reg && curAddr_reg == ADDR_RST && page_reg == PAGE_RST
                                   && !tcFlag_reg && !ctlDisable_reg)
    else $error("master clear left state");
  a_auto_reload: assert property (tcHit && mode_reg.autoReload && !wrEn
                                  |=> curCount_reg == $past(baseCount_reg)
                                  && curAddr_reg == $past(baseAddr_reg))
    else $error("auto reload missed");
  a_window_miss: assert property (ioReq.wr && !inWin |=> $stable(page_reg))
    else $error("write outside window took effect");
  a_disable_stops: assert property (ctlDisable_reg && transferDone
                                    |=> $stable(curCount_reg) || $past(wrEn))
    else $error("disabled channel counted");

endmodule // ddm_channel
`default_nettype wire

// ### core/ddm_pkg.sv
`default_nettype none
package ddm_pkg;

  // Window layout: byte offsets inside the 16-byte I/O block
  localparam int          WIN_BASE_W    = 12;
  localparam int          WIN_OFS_W     = 4;
  localparam logic [3:0]  OFS_ADDR_LO   = 4'h0;
  localparam logic [3:0]  OFS_ADDR_HI   = 4'h1;
  localparam logic [3:0]  OFS_PAGE      = 4'h2;
  localparam logic [3:0]  OFS_COUNT_LO  = 4'h4;
  localparam logic [3:0]  OFS_COUNT_HI  = 4'h5;
  localparam logic [3:0]  OFS_CMD_STAT  = 4'h8;
  localparam logic [3:0]  OFS_SW_REQ    = 4'h9;
  localparam logic [3:0]  OFS_MODE      = 4'hB;
  localparam logic [3:0]  OFS_MCLEAR    = 4'hD;
  localparam logic [3:0]  OFS_MASK      = 4'hF;

  // Field positions
  localparam int          CMD_DISABLE_BIT = 2;
  localparam int          MODE_SEL_HI     = 7;
  localparam int          MODE_SEL_LO     = 6;
  localparam int          MODE_DIR_BIT    = 5;
  localparam int          MODE_AUTO_BIT   = 4;
  localparam int          MODE_TYPE_HI    = 3;
  localparam int          MODE_TYPE_LO    = 2;
  localparam int          MASK_BIT        = 0;

  // Mode encodings
  localparam logic [1:0]  SEL_DEMAND    = 2'h0;
  localparam logic [1:0]  SEL_SINGLE    = 2'h1;
  localparam logic [1:0]  SEL_BLOCK     = 2'h2;
  localparam logic [1:0]  TYPE_NONE     = 2'h0;
  localparam logic [1:0]  TYPE_MEM_WR   = 2'h1;
  localparam logic [1:0]  TYPE_MEM_RD   = 2'h2;

  // Reset values
  localparam logic [15:0] ADDR_RST      = 16'h0000;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [7:0]  PAGE_RST      = 8'h00;
  localparam logic        DISABLE_RST   = 1'h0;
  localparam logic        MASK_RST      = 1'h1;
  localparam logic [7:0]  READ_ZERO     = 8'h00;

  // Count and address steps per transfer
  localparam logic [15:0] STEP_BYTE     = 16'h0001;
  localparam logic [15:0] STEP_WORD     = 16'h0002;
  localparam logic [15:0] ADDR_STEP     = 16'h0001;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ddm_io_req_t;

  typedef struct packed {
    logic [1:0] sel;
    logic       dir;
    logic       autoReload;
    logic [1:0] transfer_direction_type;
  } ddm_mode_t;

  localparam ddm_mode_t MODE_RST = '{sel: SEL_DEMAND, dir: 1'h0, autoReload: 1'h0, transfer_direction_type: TYPE_NONE};

endpackage
`default_nettype wire

// ### core/ddm_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ddm_sync
  import ddm_pkg::*;
(
  input  wire logic clk,      // System clock
  input  wire logic arst_n,   // Async reset, active low
  input  wire logic pinIn,    // Asynchronous pin level
  output var  logic levelOut  // Filtered level
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;

  // Stage one feeds only stage two
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1_reg <= 1'h0;
      stage2_reg <= 1'h0;
      stage3_reg <= 1'h0;
    end
    else
    begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Change accepted once the last two stages agree
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      levelOut <= 1'h0;
    else if (stage2_reg == stage3_reg)
      levelOut <= stage3_reg;
  end

endmodule // ddm_sync
`default_nettype wire

// ### test/ddm_channel_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ddm_channel_tb;
  import ddm_pkg::*;

  localparam logic [11:0] BASE = 12'h3A5;
  localparam time         DLY  = 10;

  logic        clk;
  logic        arst_n;
  ddm_io_req_t ioReq;
  logic        cardRequestPin;
  logic        cardPresentPin;
  logic        wide16;
  logic        transferDone;
  logic [7:0]  ioRdata;
  logic        ioRdValid;
  logic [23:0] adAddress;
  logic        channelRequest;
  logic        terminalCount;
  logic [1:0]  transferModeSel;
  logic [1:0]  transferDirType;
  logic [7:0]  rdByte;
  logic        tc;
  int          fails;
  int          numChecks;

  always #50 clk = ~clk;

  ddm_master_model pm_u (.clk(clk), .ioRdata(ioRdata), .ioRdValid(ioRdValid),
    .terminalCount(terminalCount), .ioReq(ioReq), .transferDone(transferDone));

  ddm_channel dut_u (.clk(clk), .arst_n(arst_n), .ioReq(ioReq), .windowBasePointer(BASE),
    .cardRequestPin(cardRequestPin), .cardPresentPin(cardPresentPin), .wide16(wide16),
    .transferDone(transferDone), .ioRdata(ioRdata), .ioRdValid(ioRdValid), .adAddress(adAddress),
    .channelRequest(channelRequest), .terminalCount(terminalCount),
    .transferModeSel(transferModeSel), .transferDirType(transferDirType));

  function automatic logic [15:0] win(input logic [3:0] ofs);
    return {BASE, ofs};
  endfunction

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic rd(input logic [15:0] addr, output logic [7:0] data);
    logic ok;
    pm_u.rd(addr, data, ok);
    if (ok !== 1'b1)
    begin
      fails++;
      $display("BAD read answer at %h never came", addr);
      wrap_up();
    end
  endtask

  task automatic rd_chk(input string what, input logic [3:0] ofs, input logic [7:0] exp);
    rd(win(ofs), rdByte);
    chk(what, 24'(rdByte), 24'(exp));
  endtask

  task automatic rd16_chk(input string what, input logic [3:0] ofs, input logic [15:0] exp);
    logic [7:0] lo;
    rd(win(ofs), lo);
    rd(win(ofs + 4'h1), rdByte);
    chk(what, {8'h00, rdByte, lo}, 24'(exp));
  endtask

  task automatic wr16(input logic [3:0] ofs, input logic [15:0] val);
    pm_u.wr(win(ofs), val[7:0]);
    pm_u.wr(win(ofs + 4'h1), val[15:8]);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #DLY;
  endtask

  task automatic t_reset();
    chk("adAddress", adAddress, 24'h000000);
    rd16_chk("address", OFS_ADDR_LO, ADDR_RST);
    rd_chk("page", OFS_PAGE, PAGE_RST);
    rd16_chk("count", OFS_COUNT_LO, COUNT_RST);
    rd_chk("status", OFS_CMD_STAT, 8'h00);
    $display("reset values done");
  endtask

  task automatic t_reserved();
    logic [3:0] rsv [6] = '{4'h3, 4'h6, 4'h7, 4'hA, 4'hC, 4'hE};
    logic       ok;
    foreach (rsv[i]) pm_u.wr(win(rsv[i]), 8'hFF);
    foreach (rsv[i]) rd_chk("reserved", rsv[i], READ_ZERO);
    rd_chk("request reg", OFS_SW_REQ, READ_ZERO);
    rd_chk("mode reg", OFS_MODE, READ_ZERO);
    rd_chk("clear reg", OFS_MCLEAR, READ_ZERO);
    pm_u.rd({~BASE, OFS_PAGE}, rdByte, ok);
    chk("outside window", 24'(ok), 24'h000000);
    pm_u.wr({~BASE, OFS_PAGE}, 8'h77);
    rd_chk("page outside", OFS_PAGE, PAGE_RST);
    $display("reserved places done");
  endtask

  task automatic t_addr();
    wr16(OFS_ADDR_LO, 16'h1234);
    pm_u.wr(win(OFS_PAGE), 8'hA5);
    rd_chk("page", OFS_PAGE, 8'hA5);
    rd16_chk("address", OFS_ADDR_LO, 16'h1234);
    chk("ad 8-bit", adAddress, {8'hA5, 16'h1234});
    wide16 = 1'b1;
    settle(2);
    chk("ad 16-bit", adAddress, {7'h52, 16'h1234, 1'b0});
    wide16 = 1'b0;
    $display("address phase done");
  endtask

  task automatic t_count();
    wr16(OFS_ADDR_LO, 16'h0010);
    wr16(OFS_COUNT_LO, 16'h0001);
    pm_u.xfer(tc);
    chk("tc early", 24'(tc), 24'h000000);
    rd16_chk("count", OFS_COUNT_LO, 16'h0000);
    rd16_chk("address up", OFS_ADDR_LO, 16'h0011);
    pm_u.xfer(tc);
    chk("tc", 24'(tc), 24'h000001);
    rd_chk("status tc", OFS_CMD_STAT, 8'h0F);
    rd_chk("status cleared", OFS_CMD_STAT, 8'h00);
    wide16 = 1'b1;
    wr16(OFS_COUNT_LO, 16'h0003);
    pm_u.xfer(tc);
    chk("tc16 early", 24'(tc), 24'h000000);
    rd16_chk("count16", OFS_COUNT_LO, 16'h0001);
    pm_u.xfer(tc);
    chk("tc16", 24'(tc), 24'h000001);
    wide16 = 1'b0;
    rd_chk("status tc16", OFS_CMD_STAT, 8'h0F);
    $display("counting done");
  endtask

  task automatic t_mode();
    for (int s = 0; s < 3; s++)
      for (int t = 0; t < 3; t++)
      begin
        pm_u.wr(win(OFS_MODE), {2'(s), 2'b00, 2'(t), 2'b00});
        settle(1);
        chk("mode sel", 24'(transferModeSel), 24'(s));
        chk("mode type", 24'(transferDirType), 24'(t));
      end
    pm_u.wr(win(OFS_MODE), 8'h30);
    wr16(OFS_ADDR_LO, 16'h0100);
    wr16(OFS_COUNT_LO, 16'h0001);
    pm_u.xfer(tc);
    rd16_chk("address down", OFS_ADDR_LO, 16'h00FF);
    pm_u.xfer(tc);
    chk("tc auto", 24'(tc), 24'h000001);
    rd16_chk("reload address", OFS_ADDR_LO, 16'h0100);
    rd16_chk("reload count", OFS_COUNT_LO, 16'h0001);
    rd_chk("status auto", OFS_CMD_STAT, 8'h0F);
    $display("mode done");
  endtask

  task automatic t_request();
    cardRequestPin = 1'b1;
    settle(6);
    rd_chk("flags masked", OFS_CMD_STAT, 8'hF0);
    chk("masked req", 24'(channelRequest), 24'h000000);
    pm_u.wr(win(OFS_MASK), 8'h00);
    settle(1);
    chk("card req", 24'(channelRequest), 24'h000001);
    pm_u.wr(win(OFS_CMD_STAT), 8'h04);
    settle(1);
    chk("disabled req", 24'(channelRequest), 24'h000000);
    wr16(OFS_COUNT_LO, 16'h0005);
    pm_u.xfer(tc);
    rd16_chk("count frozen", OFS_COUNT_LO, 16'h0005);
    pm_u.wr(win(OFS_CMD_STAT), 8'h00);
    settle(1);
    chk("enabled req", 24'(channelRequest), 24'h000001);
    cardPresentPin = 1'b0;
    settle(6);
    chk("removed req", 24'(channelRequest), 24'h000000);
    rd_chk("mask set", OFS_MASK, 8'h01);
    cardRequestPin = 1'b0;
    settle(6);
    rd_chk("flags idle", OFS_CMD_STAT, 8'h00);
    pm_u.sw_request(win(OFS_MODE), win(OFS_SW_REQ));
    settle(1);
    chk("sw req", 24'(channelRequest), 24'h000001);
    $display("requests done");
  endtask

  task automatic t_clear();
    // Card back in so the mask can really be cleared first
    cardPresentPin = 1'b1;
    wr16(OFS_COUNT_LO, 16'h0000);
    pm_u.xfer(tc);
    settle(4);
    pm_u.wr(win(OFS_MASK), 8'h00);
    pm_u.wr(win(OFS_SW_REQ), 8'h00);
    pm_u.wr(win(OFS_PAGE), 8'h5A);
    wr16(OFS_ADDR_LO, 16'h4321);
    wr16(OFS_COUNT_LO, 16'h0777);
    pm_u.wr(win(OFS_MCLEAR), 8'h00);
    settle(1);
    chk("req cleared", 24'(channelRequest), 24'h000000);
    rd_chk("page cleared", OFS_PAGE, PAGE_RST);
    rd16_chk("address cleared", OFS_ADDR_LO, ADDR_RST);
    rd16_chk("count cleared", OFS_COUNT_LO, COUNT_RST);
    rd_chk("tc cleared", OFS_CMD_STAT, 8'h00);
    rd_chk("mask default", OFS_MASK, 8'h01);
    $display("master clear done");
  endtask

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    cardRequestPin = 1'b0;
    cardPresentPin = 1'b1;
    wide16 = 1'b0;
    fails = 0;
    numChecks = 0;
    repeat (2) @(posedge clk);
    #DLY;
    arst_n = 1'b1;
    t_reset();
    t_reserved();
    t_addr();
    t_count();
    t_mode();
    t_request();
    t_clear();
    wrap_up();
  end
endmodule // ddm_channel_tb
`default_nettype wire

// ### test/ddm_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module ddm_master_model
  import ddm_pkg::*;
(
  input  wire logic        clk,           // System clock
  input  wire logic [7:0]  ioRdata,       // Read data
  input  wire logic        ioRdValid,     // Read data valid
  input  wire logic        terminalCount, // Terminal count pulse
  output var  ddm_io_req_t ioReq,         // Register access
  output var  logic        transferDone   // One transfer done
);
  localparam time DLY = 10;

  initial
  begin
    ioReq = '{rd: 1'b0, wr: 1'b0, addr: 16'h0000, wdata: 8'h00};
    transferDone = 1'b0;
  end

  // Released lines toggle so a stale value never passes for a live one
  task automatic release_bus();
    ioReq.rd = 1'b0;
    ioReq.wr = 1'b0;
    ioReq.addr = ~ioReq.addr;
    ioReq.wdata = ~ioReq.wdata;
  endtask

  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk);
    #DLY;
    ioReq.wr = 1'b1;
    ioReq.addr = addr;
    ioReq.wdata = data;
    @(posedge clk);
    #DLY;
    release_bus();
  endtask

  task automatic rd(input logic [15:0] addr, output logic [7:0] data, output logic ok);
    ok = 1'b0;
    data = 8'h00;
    @(posedge clk);
    #DLY;
    ioReq.rd = 1'b1;
    ioReq.addr = addr;
    @(posedge clk);
    #DLY;
    release_bus();
    for (int i = 0; i < 4 && ok == 1'b0; i++)
    begin
      if (ioRdValid === 1'b1)
      begin
        data = ioRdata;
        ok = 1'b1;
      end
      else
      begin
        @(posedge clk);
        #DLY;
      end
    end
  endtask

  task automatic xfer(output logic tc);
    @(posedge clk);
    #DLY;
    transferDone = 1'b1;
    @(posedge clk);
    #DLY;
    transferDone = 1'b0;
    tc = terminalCount;
  endtask

  // Software request only after selecting block mode
  task automatic sw_request(input logic [15:0] modeAddr, input logic [15:0] reqAddr);
    wr(modeAddr, {SEL_BLOCK, 6'h00});
    wr(reqAddr, 8'h5A);
  endtask
endmodule // ddm_master_model
`default_nettype wire
